// ### src/cdtdr_core.sv
// Cable diagnostics core: reflectometry timer and matched length capture.
// Assumes a single 125 MHz clock and synchronous analog front-end flags.
`timescale 1ns/10ps
`default_nettype none
`include "cdtdr_cfg.svh"

// Overview of operation
// - With auto crossover off, the pair comes from the manual pair select bit.
// - Pulse the transmit pair straight, the receive pair when crossed.
// - Time pulse to reflection and report it as electrical length.
// - Any established link is dropped while a test runs.
// - With 100 Mb link up, provide a length code in cable length register.
// - Registers reached by index over the serial management interface.
module cdtdr_core
  import cdtdr_pkg::*;
#(
  parameter int LEN_W = 8
)
(
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  input  wire cdtdr_pkg::cdtdr_addr_t regAddr,
  input  wire cdtdr_pkg::cdtdr_data_t regWdata,
  input  wire logic               regWrite,
  input  wire logic               regRead,
  output logic [15:0]             regRdata,
  input  wire logic               link100Up,
  input  wire logic [3:0]         matchedLengthIn,
  input  wire logic               reflectSeen,
  input  wire logic               reflectShort,
  output logic                    pulseTxPair,
  output logic                    pulseRxPair,
  output logic                    linkDrop,
  output logic                    testBusy
);
  import cdtdr_pkg::*;

  localparam int LISTEN_CYC = `CDTDR_LISTEN_NS / `CDTDR_CLK_NS;
  localparam int TICK_LAST  = LISTEN_CYC - 1;   // Last tick inside the window
  localparam int PAIR_N     = 2;                // Lane 0 transmit, lane 1 receive
  localparam int PAIR_TX    = 0;
  localparam int PAIR_RX    = 1;

  // Index match, used by the start request decode
  function automatic logic idx_hit
  (
    input cdtdr_addr_t addr,
    input cdtdr_addr_t idx
  );
    idx_hit = (addr == idx);
  endfunction : idx_hit

  // A test owns the line in these two states
  function automatic logic test_active
  (
    input cdtdr_state_e st
  );
    test_active = (st == CDTDR_PULSE) || (st == CDTDR_LISTEN);
  endfunction : test_active

  // Listening ends on an echo, at window end or when the timer would wrap
  function automatic logic listen_over
  (
    input logic             echo,
    input logic [LEN_W-1:0] tick
  );
    listen_over = echo || (32'(tick) >= TICK_LAST) || (&tick);
  endfunction : listen_over

  // Crossed only with auto crossover off and the manual select set
  function automatic logic pair_crossed
  (
    input logic xoverOff,
    input logic pairSel
  );
    pair_crossed = xoverOff && pairSel;
  endfunction : pair_crossed

  cdtdr_state_e     state_r;
  logic             pairSelectOverride_r;
  logic             autoXoverOff_r;
  logic [LEN_W-1:0] tdrLen_r;
  logic [LEN_W-1:0] tick_r;
  logic             tdrDone_r;
  logic             tdrShort_r;
  logic             tdrValid_r;
  logic [3:0]       matchedLengthCode_r;
  logic             startTest;
  logic [PAIR_N-1:0] pairPulse_r;
  logic             listenEnd;
  logic             crossed;

  // Start request: write of the enable bit while no test owns the line
  assign startTest = regWrite && idx_hit(regAddr, `CDTDR_IDX_TDRCS) && regWdata[`CDTDR_TDR_EN_BIT]
                     && !test_active(state_r);

  // End of the listening window, echo or timeout
  assign listenEnd = (state_r == CDTDR_LISTEN) && listen_over(reflectSeen, tick_r);

  // Pair choice from the mode register
  assign crossed = pair_crossed(autoXoverOff_r, pairSelectOverride_r);

  // Mode control register holding pair select and crossover disable
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      pairSelectOverride_r <= 1'b0;
      autoXoverOff_r       <= 1'b0;
    end
    else if (regWrite && (regAddr == `CDTDR_IDX_MODECS))
    begin
      pairSelectOverride_r <= regWdata[`CDTDR_PAIR_SEL_BIT];
      autoXoverOff_r       <= regWdata[`CDTDR_AUTOX_DIS_BIT];
    end
  end

  // Test sequencer: pulse, listen, done
  // A start is only taken outside pulse and listen, so a second
  // write during a test cannot restart the timer halfway through.
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      state_r <= CDTDR_IDLE;
      tick_r  <= '0;
    end
    else
    begin
      unique case (state_r)
        CDTDR_IDLE, CDTDR_DONE:
        begin
          if (startTest)
          begin
            state_r <= CDTDR_PULSE;
            tick_r  <= '0;
          end
        end
        CDTDR_PULSE:
        begin
          state_r <= CDTDR_LISTEN;
          tick_r  <= '0;
        end
        CDTDR_LISTEN:
        begin
          // Time from pulse to reflection; give up at window end
          if (listenEnd)
            state_r <= CDTDR_DONE;
          else
            tick_r <= tick_r + 1'b1;
        end
      endcase
    end
  end

  // Result capture, held until next start or reset
  // Done and valid are cleared only by a new start, never by a read,
  // so software may poll the result any number of times.
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      tdrLen_r   <= '0;
      tdrDone_r  <= 1'b0;
      tdrShort_r <= 1'b0;
      tdrValid_r <= 1'b0;
    end
    else if (startTest)
    begin
      tdrLen_r   <= '0;
      tdrDone_r  <= 1'b0;
      tdrShort_r <= 1'b0;
      tdrValid_r <= 1'b0;
    end
    else if (state_r == CDTDR_LISTEN)
    begin
      if (reflectSeen)
      begin
        tdrLen_r   <= tick_r;
        tdrShort_r <= reflectShort;
        tdrValid_r <= 1'b1;
        tdrDone_r  <= 1'b1;
      end
      else if (listenEnd)
        tdrDone_r  <= 1'b1;         // No echo: length marked invalid
    end
  end

  // One drive flop per pair, lane chosen by the crossover setting
  for (genvar g = 0; g < PAIR_N; g++)
  begin : g_pair
    always_ff @(posedge sys_clk)
    begin
      if (!resetn)
        pairPulse_r[g] <= 1'b0;
      else
        pairPulse_r[g] <= startTest && (crossed == (g == PAIR_RX));
    end
  end : g_pair

  // Pulse outputs straight from the lane flops
  assign pulseTxPair = pairPulse_r[PAIR_TX];
  assign pulseRxPair = pairPulse_r[PAIR_RX];

  // Busy follows the sequencer's next state; link drop follows a start or the current pulse or listen state
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      linkDrop <= 1'b0;
      testBusy <= 1'b0;
    end
    else
    begin
      linkDrop <= startTest || test_active(state_r);
      // Busy drops on the edge that leaves listening, echo or timeout
      testBusy <= startTest || (state_r == CDTDR_PULSE)
                  || ((state_r == CDTDR_LISTEN) && !listenEnd);
    end
  end

  // Matched length code tracked while a 100 Mb link is up
  // Without the link the last code is held, not cleared,
  // and software is expected to disregard it then.
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      matchedLengthCode_r <= 4'h0;
    else if (link100Up)
      matchedLengthCode_r <= matchedLengthIn;
  end

  // Register images assembled from the field positions
  logic [15:0] tdrImage;
  logic [15:0] modeImage;
  logic [15:0] cblenImage;
  logic [15:0] phyImage;

  // Reflectometry status image
  always_comb
  begin
    tdrImage                       = 16'h0000;
    tdrImage[`CDTDR_TDR_EN_BIT]    = test_active(state_r);
    tdrImage[`CDTDR_TDR_DONE_BIT]  = tdrDone_r;
    tdrImage[`CDTDR_TDR_SHORT_BIT] = tdrShort_r;
    tdrImage[`CDTDR_TDR_VALID_BIT] = tdrValid_r;
    tdrImage[`CDTDR_TDR_LEN_MSB:0] = 8'(tdrLen_r);
  end

  // Mode image
  always_comb
  begin
    modeImage                       = `CDTDR_MODECS_RST;
    modeImage[`CDTDR_PAIR_SEL_BIT]  = pairSelectOverride_r;
    modeImage[`CDTDR_AUTOX_DIS_BIT] = autoXoverOff_r;
  end

  // Length code sits in the top nibble
  always_comb
  begin
    cblenImage                        = 16'h0000;
    cblenImage[`CDTDR_MATCHED_LENGTH_CODE_LSB +: 4]  = matchedLengthCode_r;
  end

  // Physical status image
  always_comb
  begin
    phyImage                     = 16'h0000;
    phyImage[`CDTDR_LINK100_BIT] = link100Up;
  end

  // Register read port, data one cycle after the strobe
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      regRdata <= 16'h0000;
    else if (regRead)
    begin
      unique case (regAddr)
        `CDTDR_IDX_TDRCS:
          regRdata <= tdrImage;
        `CDTDR_IDX_MODECS:
          regRdata <= modeImage;
        `CDTDR_IDX_CBLEN:
          regRdata <= cblenImage;
        `CDTDR_IDX_PHYCTL:
          regRdata <= phyImage;
        default:
          regRdata <= 16'h0000;
      endcase
    end
    else
      regRdata <= 16'h0000;
  end

endmodule : cdtdr_core
`default_nettype wire

// ### src/cdtdr_cfg.svh
// Register indices, field positions, reset values and timing counts for cable diagnostics.
// Assumes inclusion by the diagnostics package and core only.
`ifndef CDTDR_CFG_SVH
`define CDTDR_CFG_SVH
// Register indices (management register numbers)
`define CDTDR_IDX_TDRCS   5'h19
`define CDTDR_IDX_CBLEN   5'h1C
`define CDTDR_IDX_MODECS  5'h1B
`define CDTDR_IDX_PHYCTL  5'h1F
// Reflectometry control/status fields
`define CDTDR_TDR_EN_BIT     15
`define CDTDR_TDR_DONE_BIT   14
`define CDTDR_TDR_SHORT_BIT  13
`define CDTDR_TDR_VALID_BIT  12
`define CDTDR_TDR_LEN_MSB    7
// Mode control fields
`define CDTDR_PAIR_SEL_BIT   15
`define CDTDR_AUTOX_DIS_BIT  14
// Physical control fields
`define CDTDR_LINK100_BIT    0
// Cable length field position
`define CDTDR_MATCHED_LENGTH_CODE_LSB       12
// Reset values
`define CDTDR_MODECS_RST     16'h0000
// Listening window after a pulse, in ns
`define CDTDR_LISTEN_NS      2000
`define CDTDR_CLK_NS         8
`endif

// ### src/cdtdr_pkg.sv
// Types shared by the cable diagnostics logic.
// Assumes the configuration header is on the include path.
`include "cdtdr_cfg.svh"
package cdtdr_pkg;
  typedef logic [4:0]  cdtdr_addr_t;
  typedef logic [15:0] cdtdr_data_t;
  typedef enum logic [1:0]
  {
    CDTDR_IDLE   = 2'b00,
    CDTDR_PULSE  = 2'b01,
    CDTDR_LISTEN = 2'b10,
    CDTDR_DONE   = 2'b11
  } cdtdr_state_e;
endpackage : cdtdr_pkg

// ### verif/cdtdr_chk.sv
// Port checker for the cable diagnostics core.
// Assumes binding to cdtdr_core and one clock domain.
`timescale 1ns/10ps
`default_nettype none
module cdtdr_chk
(
  input wire logic               sys_clk,
  input wire logic               resetn,
  input wire cdtdr_pkg::cdtdr_addr_t regAddr,
  input wire cdtdr_pkg::cdtdr_data_t regWdata,
  input wire logic               regWrite,
  input wire logic               regRead,
  input wire logic [15:0]        regRdata,
  input wire logic               link100Up,
  input wire logic [3:0]         matchedLengthIn,
  input wire logic               reflectSeen,
  input wire logic               reflectShort,
  input wire logic               pulseTxPair,
  input wire logic               pulseRxPair,
  input wire logic               linkDrop,
  input wire logic               testBusy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [1:0] modeSel_r;
  wire        pulseAny = pulseTxPair || pulseRxPair;
  // Mirror of pair mode bits
  always_ff @(posedge sys_clk)
    if (!resetn)
      modeSel_r <= 2'h0;
    else if (regWrite && regAddr == 5'h1B)
      modeSel_r <= regWdata[15:14];
  sequence startWr;
    regWrite && regAddr == 5'h19 && regWdata[15];
  endsequence
  start_pulse_a: assert property (startWr ##0 !testBusy |=> pulseAny) else $error("no pulse");
  busy_ignore_a: assert property (startWr ##0 testBusy |=> !pulseAny) else $error("restart");
  busy_start_a: assert property (startWr ##0 !testBusy |=> testBusy) else $error("not busy");
  pair_sel_a: assert property (pulseAny |-> pulseRxPair == (modeSel_r == 2'h3) && pulseTxPair != pulseRxPair)
    else $error("wrong pair");
  link_drop_a: assert property (pulseAny |-> linkDrop ##1 linkDrop) else $error("link kept");
  idle_read_a: assert property (!regRead |=> regRdata == 16'h0000) else $error("stray data");
  cable_len_a: assert property (regRead && regAddr == 5'h1C && link100Up && $past(link100Up) && $past(resetn)
    && $stable(matchedLengthIn) |=> regRdata == {$past(matchedLengthIn), 12'h000}) else $error("bad code");
  window_a: assert property ($rose(testBusy) |-> ##[1:300] !testBusy) else $error("hung test");
  echo_stop_a: assert property (reflectSeen && linkDrop && !pulseAny |-> ##[1:2] !linkDrop)
    else $error("drop kept");
endmodule : cdtdr_chk
bind cdtdr_core cdtdr_chk i_chk (.sys_clk, .resetn, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
  .link100Up, .matchedLengthIn, .reflectSeen, .reflectShort, .pulseTxPair, .pulseRxPair, .linkDrop, .testBusy);
`default_nettype wire

// ### verif/cdtdr_cable.sv
// Cable model returning an echo a set delay after a test pulse.
// Assumes pulses last one cycle.
`timescale 1ns/10ps
`default_nettype none
module cdtdr_cable
(
  input  wire logic       sys_clk,
  input  wire logic       pulseTxPair,
  input  wire logic       pulseRxPair,
  input  wire logic [7:0] echoDelay,
  input  wire logic       echoOn,
  input  wire logic       echoShort,
  output logic            reflectSeen,
  output logic            reflectShort
);
  int cnt_r = 0;
  // Flight time counter
  always_ff @(posedge sys_clk)
    if (pulseTxPair || pulseRxPair)
      cnt_r <= echoDelay + 1;
    else if (cnt_r != 0)
      cnt_r <= cnt_r - 1;
  // Terminated line gives no echo; kind line toggles while the flight counter runs
  assign reflectSeen = echoOn && cnt_r == 1;
  assign reflectShort = reflectSeen ? echoShort : cnt_r[0];
endmodule : cdtdr_cable
`default_nettype wire

// ### verif/cable_diagnostics_tdr_tb_top.sv
// Self-checking bench for the cable diagnostics core.
// Assumes the core, checker and cable model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module cable_diagnostics_tdr_tb_top;
  import cdtdr_pkg::*;
  logic sys_clk = 0, resetn = 0, regWrite = 0, regRead = 0, link100Up = 0, echoOn = 0, echoShort = 0;
  logic reflectSeen, reflectShort, pulseTxPair, pulseRxPair, linkDrop, testBusy;
  cdtdr_addr_t regAddr = 5'h00;
  cdtdr_data_t regWdata = 16'h0000;
  logic [15:0] regRdata, got, exp;
  logic [3:0] matchedLengthIn = 4'h0;
  logic [7:0] echoDelay = 8'h08;
  logic [3:0] pl;
  int bad_count = 0, checked = 0, seed = 97, n, pc;
  int codeQ[$];
  int cblnM[16] = '{0, 0, 0, 0, 6, 17, 27, 38, 49, 59, 70, 81, 91, 102, 113, 123};
  cdtdr_core i_dut (.sys_clk, .resetn, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .link100Up,
    .matchedLengthIn, .reflectSeen, .reflectShort, .pulseTxPair, .pulseRxPair, .linkDrop, .testBusy);
  cdtdr_cable i_cable (.sys_clk, .pulseTxPair, .pulseRxPair, .echoDelay, .echoOn, .echoShort, .reflectSeen,
    .reflectShort);
  initial forever #4 sys_clk = ~sys_clk;
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask : chk
  task automatic end_sim;
    if (bad_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // One bus cycle, then the answer cycle
  task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
    regWrite <= w;
    regRead <= !w;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    #1 got = regRdata;
    pl = {testBusy, pulseRxPair, pulseTxPair, linkDrop};
    @(posedge sys_clk);
  endtask : bus
  // Main sequence
  initial
  begin
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    bus(0, 5'h1B, 0);
    chk("mode", got, 16'h0000);
    bus(0, 5'h05, 0);
    chk("unmapped", got, 16'h0000);
    for (int m = 0; m < 4; m++)
    begin
      bus(1, 5'h1B, {m[0], 15'h4000});
      echoDelay <= 8'(($random(seed) & 127) + 8);
      echoShort <= 1'($random(seed));
      echoOn <= m != 2;
      bus(1, 5'h19, 16'h8000);
      chk("pair", 16'(pl), m[0] ? 16'hD : 16'hB);
      bus(1, 5'h19, 16'h8000);
      chk("restart", 16'(pl), 16'h9);
      n = 0;
      while (testBusy && n < 300)
      begin
        @(posedge sys_clk);
        #1 n++;
      end
      chk("wait", 16'(n / 300), 16'h0000);
      if (n == 300)
        end_sim();
      @(posedge sys_clk);
      exp = echoOn ? {2'b01, echoShort, 1'b1, 4'h0, echoDelay} : 16'h4000;
      repeat (2)
      begin
        bus(0, 5'h19, 0);
        chk("result", got & (echoOn ? 16'hFFFF : 16'hD000), exp);
      end
      pc = echoShort ? 793 : 769;
      if (echoOn)
        chk("distance", 16'(got[7:0] * pc / 1000), 16'(echoDelay * pc / 1000));
    end
    link100Up <= 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      matchedLengthIn <= 4'($random(seed));
      repeat (2) @(posedge sys_clk);
      codeQ.push_back(matchedLengthIn);
      if (k == 3)
      begin
        link100Up <= 1'b0;
        matchedLengthIn <= ~matchedLengthIn;
        repeat (2) @(posedge sys_clk);
      end
      bus(0, 5'h1C, 0);
      exp = {4'(codeQ.pop_front()), 12'h000};
      chk("code", got, exp);
      chk("metres", 16'(cblnM[got[15:12]]), 16'(cblnM[exp[15:12]]));
      bus(0, 5'h1F, 0);
      chk("link", got, {15'h0000, link100Up});
      link100Up <= 1'b1;
    end
    end_sim();
  end
endmodule : cable_diagnostics_tdr_tb_top
`default_nettype wire
